/* File: lsp_pkg.sv */
`default_nettype none
package lsp_pkg;
   // Carry block geometry
   localparam int CARRY_W = 4;
   localparam int CARRY_MSB = 3;
   // Distributed RAM geometry, single and dual port default depth 64
   localparam int RAM_AW_DEFAULT = 6;
   localparam int QUAD_AW = 5;
   localparam int QUAD_DW = 2;
   // Addressable shift register geometry
   localparam int SRL_DEPTH = 32;
   localparam int SRL_AW = 5;
   localparam int SRL_TAIL = 31;
   localparam logic [31:0] SRL_RESET = 32'h0000_0000;
   // Storage element forced and power-up values
   localparam logic FF_CLEAR_VAL = 1'h0;
   localparam logic FF_PRESET_VAL = 1'h1;
   localparam int FF_COUNT = 4;

   // Source of the carry into the lowest bit
   typedef enum logic [1:0] {
      LSP_CY_ADD,
      LSP_CY_SUB,
      LSP_CY_BYPASS,
      LSP_CY_CASCADE
   } lsp_carry_src_t;

   typedef struct packed {
      logic [CARRY_W-1:0] generate_terms;
      logic [CARRY_W-1:0] propagate_terms;
   } lsp_carry_in_t;

   typedef struct packed {
      logic [CARRY_W-1:0] sum;
      logic [CARRY_W-1:0] per_bit_carry_out;
      logic chain_carry_out;
   } lsp_carry_out_t;

   typedef struct packed {
      logic [QUAD_AW-1:0] port_a_address;
      logic [QUAD_AW-1:0] port_b_address;
      logic [QUAD_AW-1:0] port_c_address;
      logic [QUAD_AW-1:0] port_d_address;
   } lsp_quad_addr_t;

   typedef struct packed {
      logic [QUAD_DW-1:0] port_a_read_out;
      logic [QUAD_DW-1:0] port_b_read_out;
      logic [QUAD_DW-1:0] port_c_read_out;
      logic [QUAD_DW-1:0] port_d_read_out;
   } lsp_quad_data_t;
endpackage
`default_nettype wire

/* File: lsp_slice.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// - A two-input wide mux passes input zero on low select, input one on high
// - First level joins two lookup outputs; second level joins both first-level muxes
// - Carry block gives a carry per bit; the top one is the chain output
// - Carry block accepts the previous block's chain carry as its input
// - Data inputs are per-bit generate terms, select inputs per-bit propagate terms
// - First carry is zero for add, one for subtract, or bypass input
// - RAM set covers single, dual and quad port, 32 to 256 bits deep
// - All RAM ports read the same cells through their own addresses
// - RAM data is one bit wide except quad port, which is multi-bit
// - Active write edge with enable stores data; without enable nothing changes
// - RAM write clock polarity selectable, rising edge by default
// - Read outputs follow addresses continuously; write port shows new data after write
// - Shift enable loads serial input into bit zero and moves bits up
// - Five-bit address selects which of bits 0 to 31 is read
// - Cascade output always shows bit 31 and updates after each shift
// - Addressed shift read follows address changes without a clock edge
// - Shift clock polarity selectable, rising edge by default
// - Clock enable low ignores data; set and reset override the enable
// - Sync reset variant forces low at the edge and powers up low
// - Sync set variant forces high at the edge and powers up high
// - Async clear variant forces low at once and powers up low
// - Async preset variant forces high at once and powers up high
module lsp_slice #(
   parameter int RAM_AW = lsp_pkg::RAM_AW_DEFAULT,
   parameter bit RAM_CLK_INV = 1'b0,
   parameter bit SHIFT_CLK_INV = 1'b0,
   parameter bit FF_CLK_INV = 1'b0
) (
   // Clock and power-up reset
   input wire logic sys_clk,
   input wire logic rst,
   // Wide multiplexers
   input wire logic [3:0] lut_out,
   input wire logic [1:0] pair_select,
   input wire logic top_select,
   output logic lower_pair_mux_out,
   output logic upper_pair_mux_out,
   output logic top_level_mux_out,
   // Four-bit carry block
   input wire lsp_pkg::lsp_carry_in_t carry_terms,
   input wire lsp_pkg::lsp_carry_src_t first_carry_source,
   input wire logic bypass_a_input,
   input wire logic cascade_carry_input,
   output lsp_pkg::lsp_carry_out_t carry_result,
   // Single and dual port distributed RAM
   input wire logic port_d_write_enable,
   input wire logic [RAM_AW-1:0] ram_address,
   input wire logic [RAM_AW-1:0] second_read_address,
   input wire logic ram_write_data,
   output logic primary_read_out,
   output logic secondary_read_out,
   // Quad port distributed RAM
   input wire logic quad_write_enable,
   input wire lsp_pkg::lsp_quad_addr_t quad_address,
   input wire logic [lsp_pkg::QUAD_DW-1:0] quad_write_data,
   output lsp_pkg::lsp_quad_data_t quad_read_out,
   // Addressable shift register
   input wire logic shift_enable,
   input wire logic shift_data_in,
   input wire logic [lsp_pkg::SRL_AW-1:0] shift_address,
   output logic shift_addressed_out,
   output logic shift_tail_out,
   // Storage elements
   input wire logic ff_enable,
   input wire logic [lsp_pkg::FF_COUNT-1:0] ff_data,
   input wire logic sync_reset_in,
   input wire logic sync_set_in,
   input wire logic async_clear_in,
   input wire logic async_preset_in,
   output logic [lsp_pkg::FF_COUNT-1:0] ff_q
);
   ////////////////////////////////////////////////////////////////////////
   // Wide multiplexers: two pair muxes feed the top mux
   lsp_wide_mux u_lower_pair_mux (
      .data_in_zero (lut_out[0]),
      .data_in_one (lut_out[1]),
      .sel (pair_select[0]),
      .mux_out (lower_pair_mux_out)
   );
   lsp_wide_mux u_upper_pair_mux (
      .data_in_zero (lut_out[2]),
      .data_in_one (lut_out[3]),
      .sel (pair_select[1]),
      .mux_out (upper_pair_mux_out)
   );
   lsp_wide_mux u_top_level_mux (
      .data_in_zero (lower_pair_mux_out),
      .data_in_one (upper_pair_mux_out),
      .sel (top_select),
      .mux_out (top_level_mux_out)
   );

   ////////////////////////////////////////////////////////////////////////
   // Carry block
   logic first_carry;
   logic [lsp_pkg::CARRY_W:0] carry_chain;

   // Lowest carry: constant for add or subtract, bypass pin, or cascade in
   always_comb begin
      case (first_carry_source)
         lsp_pkg::LSP_CY_ADD: first_carry = 1'h0;
         lsp_pkg::LSP_CY_SUB: first_carry = 1'h1;
         lsp_pkg::LSP_CY_BYPASS: first_carry = bypass_a_input;
         lsp_pkg::LSP_CY_CASCADE: first_carry = cascade_carry_input;
         default: first_carry = 1'h0;
      endcase
   end

   assign carry_chain[0] = first_carry;

   // Per-bit carry mux and sum xor; the ripple is the whole lookahead here
   genvar gi;
   generate
      for (gi = 0; gi < lsp_pkg::CARRY_W; gi++) begin : g_carry
         assign carry_chain[gi+1] = carry_terms.propagate_terms[gi] ?
            carry_chain[gi] : carry_terms.generate_terms[gi];
         assign carry_result.sum[gi] =
            carry_terms.propagate_terms[gi] ^ carry_chain[gi];
      end
   endgenerate

   // Every carry comes out, the top one also drives the chain output
   assign carry_result.per_bit_carry_out = carry_chain[lsp_pkg::CARRY_W:1];
   assign carry_result.chain_carry_out = carry_chain[lsp_pkg::CARRY_W];

   ////////////////////////////////////////////////////////////////////////
   // Single and dual port RAM, one bit wide, depth set by RAM_AW (5 to 8)
   logic ram_clk;
   logic ram_cells [2**RAM_AW];
   // Cells power up unknown; nothing may rely on a read before the first write

   // Polarity option only, the write path itself is unchanged
   assign ram_clk = sys_clk ^ RAM_CLK_INV;

   // Write port; contents are not reset, as in a real lookup-table RAM
   always_ff @(posedge ram_clk) begin
      if (port_d_write_enable) begin
         ram_cells[ram_address] <= ram_write_data;
      end
   end

   // Both reads are combinational on the shared cells
   assign primary_read_out = ram_cells[ram_address];
   assign secondary_read_out = ram_cells[second_read_address];

   ////////////////////////////////////////////////////////////////////////
   // Quad port RAM: three read ports and one read/write port on one array
   logic [lsp_pkg::QUAD_DW-1:0] quad_cells [2**lsp_pkg::QUAD_AW];

   always_ff @(posedge ram_clk) begin
      if (quad_write_enable) begin
         quad_cells[quad_address.port_d_address] <= quad_write_data;
      end
   end

   // Each port reads independently through its own address
   assign quad_read_out.port_a_read_out = quad_cells[quad_address.port_a_address];
   assign quad_read_out.port_b_read_out = quad_cells[quad_address.port_b_address];
   assign quad_read_out.port_c_read_out = quad_cells[quad_address.port_c_address];
   assign quad_read_out.port_d_read_out = quad_cells[quad_address.port_d_address];

   ////////////////////////////////////////////////////////////////////////
   // Addressable shift register, 32 deep, with tail cascade output
   logic shift_clk;
   logic [lsp_pkg::SRL_DEPTH-1:0] shift_bits;

   assign shift_clk = sys_clk ^ SHIFT_CLK_INV;

   // Shift up by one on enable, bit zero takes the serial input
   always_ff @(posedge shift_clk) begin
      if (rst) begin
         shift_bits <= lsp_pkg::SRL_RESET;
      end else if (shift_enable) begin
         shift_bits <= {shift_bits[lsp_pkg::SRL_DEPTH-2:0], shift_data_in};
      end
   end

   // Address read is combinational so a moving address sees no delay
   assign shift_addressed_out = shift_bits[shift_address];
   // Tail ignores the address and moves only with a shift or with rst, which clears it
   assign shift_tail_out = shift_bits[lsp_pkg::SRL_TAIL];

   ////////////////////////////////////////////////////////////////////////
   // Storage elements: one of each variant, all on one shared polarity
   lsp_storage_flop #(
      .ASYNC (1'b0),
      .FORCE_VAL (lsp_pkg::FF_CLEAR_VAL),
      .CLK_INV (FF_CLK_INV)
   ) u_sync_reset_flop (
      .sys_clk (sys_clk),
      .rst (rst),
      .ce (ff_enable),
      .d (ff_data[0]),
      .force_in (sync_reset_in),
      .q (ff_q[0])
   );
   lsp_storage_flop #(
      .ASYNC (1'b0),
      .FORCE_VAL (lsp_pkg::FF_PRESET_VAL),
      .CLK_INV (FF_CLK_INV)
   ) u_sync_set_flop (
      .sys_clk (sys_clk),
      .rst (rst),
      .ce (ff_enable),
      .d (ff_data[1]),
      .force_in (sync_set_in),
      .q (ff_q[1])
   );
   lsp_storage_flop #(
      .ASYNC (1'b1),
      .FORCE_VAL (lsp_pkg::FF_CLEAR_VAL),
      .CLK_INV (FF_CLK_INV)
   ) u_async_clear_flop (
      .sys_clk (sys_clk),
      .rst (rst),
      .ce (ff_enable),
      .d (ff_data[2]),
      .force_in (async_clear_in),
      .q (ff_q[2])
   );
   lsp_storage_flop #(
      .ASYNC (1'b1),
      .FORCE_VAL (lsp_pkg::FF_PRESET_VAL),
      .CLK_INV (FF_CLK_INV)
   ) u_async_set_flop (
      .sys_clk (sys_clk),
      .rst (rst),
      .ce (ff_enable),
      .d (ff_data[3]),
      .force_in (async_preset_in),
      .q (ff_q[3])
   );

   ////////////////////////////////////////////////////////////////////////
   // Checks; edge-sensitive ones only apply at default rising polarity
   // Async forces are checked one edge after they rise, once the sampled value settles
   a_top_mux_path: assert property (@(posedge sys_clk) disable iff (rst)
      top_level_mux_out == (top_select ? lut_out[{1'b1, pair_select[1]}]
                                       : lut_out[{1'b0, pair_select[0]}]))
      else $error("top mux does not follow selects");

   a_mux_low_sel: assert property (@(posedge sys_clk) disable iff (rst)
      !pair_select[0] |-> lower_pair_mux_out == lut_out[0])
      else $error("low select did not pass input zero");

   a_mux_high_sel: assert property (@(posedge sys_clk) disable iff (rst)
      pair_select[1] |-> upper_pair_mux_out == lut_out[3])
      else $error("high select did not pass input one");

   a_carry_top_out: assert property (@(posedge sys_clk) disable iff (rst)
      (&carry_terms.propagate_terms && first_carry_source == lsp_pkg::LSP_CY_SUB)
      |-> carry_result.chain_carry_out && carry_result.sum == 4'h0)
      else $error("full propagate did not pass carry to chain output");

   a_carry_cascade: assert property (@(posedge sys_clk) disable iff (rst)
      (first_carry_source == lsp_pkg::LSP_CY_CASCADE && carry_terms.propagate_terms[0])
      |-> carry_result.per_bit_carry_out[0] == cascade_carry_input)
      else $error("cascade carry not used at bit zero");

   a_carry_bypass: assert property (@(posedge sys_clk) disable iff (rst)
      (first_carry_source == lsp_pkg::LSP_CY_BYPASS && carry_terms.propagate_terms[0])
      |-> carry_result.per_bit_carry_out[0] == bypass_a_input)
      else $error("bypass input not used as first carry");

   a_carry_add_sum: assert property (@(posedge sys_clk) disable iff (rst)
      first_carry_source == lsp_pkg::LSP_CY_ADD
      |-> carry_result.sum[0] == carry_terms.propagate_terms[0])
      else $error("add mode sum bit zero is not the propagate term");

   a_carry_generate: assert property (@(posedge sys_clk) disable iff (rst)
      !carry_terms.propagate_terms[lsp_pkg::CARRY_MSB]
      |-> carry_result.chain_carry_out == carry_terms.generate_terms[lsp_pkg::CARRY_MSB])
      else $error("generate term not taken when propagate low");

   a_ram_write_seen: assert property (@(posedge sys_clk) disable iff (rst)
      (!RAM_CLK_INV && port_d_write_enable) ##1 $stable(ram_address)
      |-> primary_read_out == $past(ram_write_data))
      else $error("written bit not shown on primary read");

   a_ram_no_write: assert property (@(posedge sys_clk) disable iff (rst)
      (!RAM_CLK_INV && !port_d_write_enable) ##1 $stable(second_read_address)
      |-> $stable(secondary_read_out))
      else $error("ram cell changed without write enable");

   a_ram_shared_cells: assert property (@(posedge sys_clk) disable iff (rst)
      (second_read_address == ram_address) |-> secondary_read_out == primary_read_out)
      else $error("ports disagree on same address");

   a_quad_write_seen: assert property (@(posedge sys_clk) disable iff (rst)
      (!RAM_CLK_INV && quad_write_enable) ##1 $stable(quad_address.port_d_address)
      |-> quad_read_out.port_d_read_out == $past(quad_write_data))
      else $error("quad write word not shown on port d");

   a_shift_move: assert property (@(posedge sys_clk) disable iff (rst)
      (!SHIFT_CLK_INV && shift_enable) ##1 !rst
      |-> shift_tail_out == $past(shift_bits[lsp_pkg::SRL_TAIL-1])
          && shift_bits[0] == $past(shift_data_in))
      else $error("shift did not move bits by one");

   a_shift_hold: assert property (@(posedge sys_clk) disable iff (rst)
      (!SHIFT_CLK_INV && !shift_enable) ##1 !rst |-> $stable(shift_bits))
      else $error("shift register moved without enable");

   a_shift_addr_zero: assert property (@(posedge sys_clk) disable iff (rst)
      (!SHIFT_CLK_INV && shift_enable) ##1 (!rst && shift_address == 5'h00)
      |-> shift_addressed_out == $past(shift_data_in))
      else $error("address zero does not show newest bit");

   a_flop_sync_reset: assert property (@(posedge sys_clk) disable iff (rst)
      (!FF_CLK_INV && sync_reset_in) |=> !ff_q[0])
      else $error("sync reset did not force low");

   a_flop_sync_set: assert property (@(posedge sys_clk) disable iff (rst)
      (!FF_CLK_INV && sync_set_in) |=> ff_q[1])
      else $error("sync set did not force high");

   a_flop_async_clear: assert property (@(posedge sys_clk) disable iff (rst)
      (async_clear_in && $past(async_clear_in)) |-> !ff_q[2])
      else $error("async clear not holding output low");

   a_flop_async_preset: assert property (@(posedge sys_clk) disable iff (rst)
      (async_preset_in && $past(async_preset_in)) |-> ff_q[3])
      else $error("async preset not holding output high");

   a_flop_ce_hold: assert property (@(posedge sys_clk) disable iff (rst)
      (!FF_CLK_INV && !ff_enable && !sync_reset_in) ##1 !rst |-> $stable(ff_q[0]))
      else $error("flop changed with enable low");

   a_flop_capture: assert property (@(posedge sys_clk) disable iff (rst)
      (!FF_CLK_INV && ff_enable && !sync_set_in) ##1 !rst |-> ff_q[1] == $past(ff_data[1]))
      else $error("enabled flop did not capture data");

   a_flop_async_capture: assert property (@(posedge sys_clk) disable iff (rst)
      (!FF_CLK_INV && ff_enable && !async_clear_in) ##1 (!rst && !async_clear_in)
      |-> ff_q[2] == $past(ff_data[2]))
      else $error("enabled async clear flop did not capture data");
endmodule
`default_nettype wire

/* File: lsp_storage_flop.sv */
`timescale 1ns/1ps
`default_nettype none
module lsp_storage_flop #(
   parameter bit ASYNC = 1'b0,
   parameter logic FORCE_VAL = 1'h0,
   parameter bit CLK_INV = 1'b0
) (
   // Clock and power-up
   input wire logic sys_clk,
   input wire logic rst,
   // Data and controls
   input wire logic ce,
   input wire logic d,
   input wire logic force_in,
   // Output
   output logic q
);
   logic flop_clk;

   // Inversion option on the clock pin; no gating, only a polarity choice
   assign flop_clk = sys_clk ^ CLK_INV;

   ////////////////////////////////////////////////////////////////////////
   generate
      if (ASYNC) begin : g_async
         // Clear or preset acts at once; power-up value equals the forced one
         always_ff @(posedge flop_clk or posedge force_in) begin
            if (force_in) begin
               q <= FORCE_VAL;
            end else if (rst) begin
               q <= FORCE_VAL;
            end else if (ce) begin
               q <= d;
            end
         end
      end else begin : g_sync
         // Reset or set wins over the enable at the active edge
         always_ff @(posedge flop_clk) begin
            if (rst) begin
               q <= FORCE_VAL;
            end else if (force_in) begin
               q <= FORCE_VAL;
            end else if (ce) begin
               q <= d;
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

/* File: lsp_user_logic.sv */
`timescale 1ns/1ps
`default_nettype none
// Stands in for the carry block one slice below, whose chain output feeds ours
module lsp_user_logic (
   // Terms of the lower block
   input wire lsp_pkg::lsp_carry_in_t prev_terms,
   input wire logic prev_sub,
   // Chain carry toward the slice
   output logic prev_chain_carry
);
   ////////////////////////////////////////////////////////////////////////////////
   // Lower block ripple; its first carry is the add or subtract constant
   always_comb begin
      logic c;
      c = prev_sub;
      for (int i = 0; i < lsp_pkg::CARRY_W; i++) begin
         c = prev_terms.propagate_terms[i] ? c : prev_terms.generate_terms[i];
      end
      prev_chain_carry = c;
   end
endmodule
`default_nettype wire

/* File: lsp_wide_mux.sv */
`timescale 1ns/1ps
`default_nettype none
module lsp_wide_mux (
   // Data
   input wire logic data_in_zero,
   input wire logic data_in_one,
   // Control
   input wire logic sel,
   // Result
   output logic mux_out
);
   // Low select passes the first input, high the second
   assign mux_out = sel ? data_in_one : data_in_zero;
endmodule
`default_nettype wire

/* File: test_logic_slice_primitives.sv */
`timescale 1ns/1ps
`default_nettype none
module test_logic_slice_primitives;
   logic sys_clk, rst, top_select, bypass_a_input, cascade_carry_input, prev_sub;
   logic [3:0] lut_out, ff_data, ff_q;
   logic [1:0] pair_select, quad_write_data;
   logic lower_pair_mux_out, upper_pair_mux_out, top_level_mux_out;
   lsp_pkg::lsp_carry_in_t carry_terms, prev_terms;
   lsp_pkg::lsp_carry_src_t first_carry_source;
   lsp_pkg::lsp_carry_out_t carry_result;
   logic port_d_write_enable, ram_write_data, primary_read_out, secondary_read_out;
   logic [5:0] ram_address, second_read_address;
   logic quad_write_enable;
   lsp_pkg::lsp_quad_addr_t quad_address;
   lsp_pkg::lsp_quad_data_t quad_read_out;
   logic shift_enable, shift_data_in, shift_addressed_out, shift_tail_out;
   logic [4:0] shift_address;
   logic ff_enable, sync_reset_in, sync_set_in, async_clear_in, async_preset_in;
   int mismatches, samples_checked;

   lsp_slice #(.RAM_AW(6)) dut_u (.sys_clk(sys_clk), .rst(rst), .lut_out(lut_out),
      .pair_select(pair_select), .top_select(top_select),
      .lower_pair_mux_out(lower_pair_mux_out), .upper_pair_mux_out(upper_pair_mux_out),
      .top_level_mux_out(top_level_mux_out), .carry_terms(carry_terms),
      .first_carry_source(first_carry_source), .bypass_a_input(bypass_a_input),
      .cascade_carry_input(cascade_carry_input), .carry_result(carry_result),
      .port_d_write_enable(port_d_write_enable), .ram_address(ram_address),
      .second_read_address(second_read_address), .ram_write_data(ram_write_data),
      .primary_read_out(primary_read_out), .secondary_read_out(secondary_read_out),
      .quad_write_enable(quad_write_enable), .quad_address(quad_address),
      .quad_write_data(quad_write_data), .quad_read_out(quad_read_out),
      .shift_enable(shift_enable), .shift_data_in(shift_data_in),
      .shift_address(shift_address), .shift_addressed_out(shift_addressed_out),
      .shift_tail_out(shift_tail_out), .ff_enable(ff_enable), .ff_data(ff_data),
      .sync_reset_in(sync_reset_in), .sync_set_in(sync_set_in),
      .async_clear_in(async_clear_in), .async_preset_in(async_preset_in), .ff_q(ff_q));

   lsp_user_logic lower_u (.prev_terms(prev_terms), .prev_sub(prev_sub),
      .prev_chain_carry(cascade_carry_input));

   ////////////////////////////////////////////////////////////////////////////////
   // One clock net for every storage element of the slice
   initial begin
      sys_clk = 1'h0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Shared compare, verdict and reference functions
   task automatic chk(input logic [8:0] exp, input logic [8:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask

   task automatic end_of_test;
      if (mismatches == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Sum, per-bit carries and chain carry, in the order of the result struct
   function automatic logic [8:0] four_bit_carry_block(input logic [3:0] g, p, input logic c0);
      logic [3:0] s, co;
      logic c;
      c = c0;
      for (int i = 0; i < 4; i++) begin
         s[i] = p[i] ^ c;
         c = p[i] ? c : g[i];
         co[i] = c;
      end
      return {s, co, co[3]};
   endfunction

   function automatic logic rd(input logic [5:0] a);
      return a[0] ^ a[3] ^ a[5];
   endfunction

   function automatic logic [1:0] qd(input logic [4:0] q);
      return q[1:0] ^ q[3:2];
   endfunction

   // Inverted so that the oldest bit is a one and the tail visibly changes
   function automatic logic pat(input int k);
      return ~(k[0] ^ k[2]);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_flop;
      chk(9'(ff_q), 9'h00a);
      @(posedge sys_clk);
      ff_enable <= 1'h1;
      ff_data <= 4'h5;
      @(posedge sys_clk);
      ff_enable <= 1'h0;
      ff_data <= 4'ha;
      #1 chk(9'(ff_q), 9'h005);
      @(posedge sys_clk);
      sync_reset_in <= 1'h1;
      sync_set_in <= 1'h1;
      #1 chk(9'(ff_q), 9'h005);
      // Set and reset win even with the enable low
      @(posedge sys_clk);
      #1 chk(9'(ff_q), 9'h006);
      @(posedge sys_clk);
      sync_reset_in <= 1'h0;
      sync_set_in <= 1'h0;
      ff_enable <= 1'h1;
      ff_data <= 4'h4;
      async_clear_in <= 1'h1;
      async_preset_in <= 1'h1;
      // Checked before any edge, so a clocked force would still show old bits
      #1 chk(9'(ff_q), 9'h00a);
      @(posedge sys_clk);
      #1 chk(9'(ff_q), 9'h008);
      @(posedge sys_clk);
      async_clear_in <= 1'h0;
      async_preset_in <= 1'h0;
      @(posedge sys_clk);
      #1 chk(9'(ff_q), 9'h004);
   endtask

   task automatic t_shift;
      for (int s = 0; s <= 32; s++) begin
         @(posedge sys_clk);
         shift_enable <= (s < 32);
         shift_data_in <= pat(s);
         #1;
         if (s > 0) begin
            chk(9'(shift_addressed_out), 9'(pat(s - 1)));
            chk(9'(shift_tail_out), 9'((s == 32) ? pat(0) : 1'h0));
         end
      end
      // Enable is low now; a one on the serial input must not get in
      for (int n = 0; n < 32; n++) begin
         @(posedge sys_clk);
         shift_address <= 5'(n);
         shift_data_in <= 1'h1;
         #1 chk(9'(shift_addressed_out), 9'(pat(31 - n)));
      end
      chk(9'(shift_tail_out), 9'(pat(0)));
   endtask

   task automatic t_mux;
      logic [6:0] v;
      logic lo, up;
      for (int i = 0; i < 128; i++) begin
         v = 7'(i);
         @(posedge sys_clk);
         lut_out <= v[3:0];
         pair_select <= v[5:4];
         top_select <= v[6];
         #1;
         lo = v[4] ? v[1] : v[0];
         up = v[5] ? v[3] : v[2];
         chk(9'({lo, up, v[6] ? up : lo}),
            9'({lower_pair_mux_out, upper_pair_mux_out, top_level_mux_out}));
      end
   endtask

   task automatic t_carry;
      logic [9:0] v;
      logic c0;
      // Every first-carry source against every generate and propagate pattern
      for (int i = 0; i < 1024; i++) begin
         v = 10'(i);
         @(posedge sys_clk);
         carry_terms <= v[7:0];
         first_carry_source <= lsp_pkg::lsp_carry_src_t'(v[9:8]);
         bypass_a_input <= v[2] ^ v[5];
         prev_terms <= ~v[7:0];
         prev_sub <= v[1];
         #1;
         case (v[9:8])
            2'h0: c0 = 1'h0;
            2'h1: c0 = 1'h1;
            2'h2: c0 = bypass_a_input;
            default: c0 = cascade_carry_input;
         endcase
         chk(four_bit_carry_block(v[7:4], v[3:0], c0), carry_result);
      end
   endtask

   task automatic t_ram;
      logic [5:0] a;
      logic [4:0] q;
      for (int i = 0; i < 64; i++) begin
         a = 6'(i);
         q = a[4:0];
         @(posedge sys_clk);
         port_d_write_enable <= 1'h1;
         ram_address <= a;
         ram_write_data <= rd(a);
         second_read_address <= a - 6'h1;
         quad_write_enable <= 1'h1;
         quad_write_data <= qd(q);
         quad_address <= {q - 5'h1, 5'h0, q - 5'h1, q};
         @(posedge sys_clk);
         #1 chk(9'(primary_read_out), 9'(rd(a)));
         chk(9'(quad_read_out.port_d_read_out), 9'(qd(q)));
         if (i > 0) begin
            chk(9'(secondary_read_out), 9'(rd(a - 6'h1)));
            chk(9'(quad_read_out[7:2]), 9'({qd(q - 5'h1), qd(5'h0), qd(q - 5'h1)}));
         end
      end
      // Write enables low: the inverted data must not land
      @(posedge sys_clk);
      port_d_write_enable <= 1'h0;
      quad_write_enable <= 1'h0;
      ram_address <= 6'h05;
      second_read_address <= 6'h05;
      ram_write_data <= ~rd(6'h05);
      quad_write_data <= ~qd(5'h05);
      quad_address <= {4{5'h05}};
      @(posedge sys_clk);
      #1 chk(9'(primary_read_out), 9'(rd(6'h05)));
      chk(9'(secondary_read_out), 9'(rd(6'h05)));
      chk(9'(quad_read_out), 9'({4{qd(5'h05)}}));
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst = 1'h1;
      {lut_out, pair_select, top_select, bypass_a_input, prev_sub} = '0;
      carry_terms = '0;
      prev_terms = '0;
      first_carry_source = lsp_pkg::LSP_CY_ADD;
      {port_d_write_enable, ram_write_data, ram_address} = '0;
      // Read ports start apart, so two unwritten cells are never compared
      second_read_address = 6'h01;
      {quad_write_enable, quad_write_data} = '0;
      quad_address = '0;
      {shift_enable, shift_data_in, shift_address} = '0;
      {ff_enable, ff_data, sync_reset_in, sync_set_in} = '0;
      {async_clear_in, async_preset_in} = '0;
      mismatches = 0;
      samples_checked = 0;
      repeat (8) @(posedge sys_clk);
      rst <= 1'h0;
      @(posedge sys_clk);
      #1;
      t_flop();
      t_shift();
      t_mux();
      t_carry();
      t_ram();
      end_of_test();
   end

   // About 1400 cycles are needed; a hang is cut off well beyond that
   initial begin
      repeat (5000) @(posedge sys_clk);
      mismatches++;
      end_of_test();
   end
endmodule
`default_nettype wire
